/* File: hw/stfg_frame_gen.sv */
// Purpose: Builds transmit-status and modem-status frames as a byte stream.
// Assumes: The host side takes bytes with a valid/ready handshake; no escaping.
// Notes: One frame is built at a time; events wait on their own handshake meanwhile.
`timescale 1ns/100ps

// How it works
// RULE_01: Finished transmit request emits frame type 0x89.
// RULE_02: Zero correlation tag suppresses transmit-status frame.
// RULE_03: Start byte, then 16-bit length field.
// RULE_04: Last byte is 0xFF minus summed bytes.
// RULE_05: Transmit-status echoes correlation tag at offset four.
// RULE_06: Delivery codes 0x00 to 0x03.
// RULE_07: Delivery codes 0x20, 0x21, 0x25, 0x31.
// RULE_08: Delivery codes 0x32, 0x34, 0x35.
// RULE_09: Delivery codes 0x74 and 0x75.
// RULE_10: Broadcast always reports delivery status success.
// RULE_11: Host uses this format only for legacy.
// RULE_12: Device events emit frame type 0x8A plus code.
// RULE_13: Modem codes 0x00 reset, 0x01 watchdog.
// RULE_14: Modem codes 0x0B wake, 0x0C sleep.
// RULE_15: Modem code 0x0D for supply fault.
// RULE_16: Modem codes 0x3B, 0x3C, 0x3D, 0x33.
// RULE_17: Power-up sends one modem frame, code 0x00.
// RULE_18: Start byte 0x7E; multi-byte fields big-endian.
module stfg_frame_gen
  import stfg_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,

  // Completed transmit requests from the radio core.
  input wire logic tx_done_valid,
  input wire stfg_tx_done_t tx_done,
  output logic tx_done_ready,

  // Device events from the radio core.
  input wire logic modem_evt_valid,
  input wire stfg_modem_cause_t modem_evt_cause,
  output logic modem_evt_ready,

  // Frame byte stream toward the host.
  output stfg_byte_t frame_out,
  output logic frame_out_valid,
  input wire logic frame_out_ready,

  // Status.
  output logic frame_busy,
  output logic boot_pending,
  output logic frame_done,
  output logic tag_suppressed,
  output logic event_rejected
);

  // All state of the generator except the running sum, which u_cksum holds.
  typedef struct packed {
    stfg_state_e_t st;
    logic is_modem;
    logic [2:0] idx;
    logic [7:0] field_a;
    logic [7:0] field_b;
    logic boot_pending;
    logic out_valid;
    stfg_byte_t out;
    logic done;
    logic suppressed;
    logic rejected;
  } stfg_gen_state_t;

  stfg_gen_state_t s_q;
  stfg_gen_state_t s_d;

  // Code bytes from the cause translator.
  logic [7:0] delivery_code;
  logic [7:0] modem_code;
  logic modem_legal;

  // Checksum control.
  logic ck_clear;
  logic ck_add;
  logic [7:0] ck_check;

  // Frame assembly helpers.
  logic slot_free;
  logic idle_open;
  logic [2:0] last_idx;
  logic [15:0] frame_len;
  logic [7:0] frame_type;
  logic [7:0] cur_byte;
  logic is_last;
  logic sending;

  // Cause translation is shared by both frame kinds.
  stfg_code_map u_code_map (
    .tx_cause(tx_done.cause),
    .tx_broadcast(tx_done.broadcast),
    .delivery_code(delivery_code),
    .modem_cause(modem_evt_cause),
    .modem_code(modem_code),
    .modem_legal(modem_legal)
  );

  // Running checksum over the bytes from the frame type onward.
  stfg_cksum u_cksum (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clear(ck_clear),
    .add(ck_add),
    .byte_in(cur_byte),
    .check(ck_check)
  );

  // The output register can take a new byte when empty or being drained.
  assign slot_free = !s_q.out_valid || frame_out_ready;

  // New events are only taken between frames, and never before the boot frame.
  assign idle_open = (s_q.st == ST_IDLE) && !s_q.boot_pending; // see RULE_17

  // Modem events take priority, so a transmit result waits while one is offered.
  assign modem_evt_ready = idle_open;
  assign tx_done_ready = idle_open && !modem_evt_valid;

  // Frame shape depends on the kind being built.
  always_comb begin
    if (s_q.is_modem) begin
      last_idx = STFG_OFS_CKSUM_MODEM;
      frame_len = STFG_LEN_MODEM;
      frame_type = STFG_TYPE_MODEM; // see RULE_12
    end else begin
      last_idx = STFG_OFS_CKSUM_TX;
      frame_len = STFG_LEN_TX_STATUS;
      frame_type = STFG_TYPE_TX_STATUS; // see RULE_01
    end
  end

  assign is_last = (s_q.idx == last_idx);

  // Byte at the current offset; the checksum always closes the frame.
  always_comb begin
    cur_byte = STFG_START_DELIM;
    if (is_last) begin
      cur_byte = ck_check; // see RULE_04
    end else begin
      unique case (s_q.idx)
        STFG_OFS_DELIM: cur_byte = STFG_START_DELIM; // see RULE_03, RULE_18
        STFG_OFS_LEN_HI: cur_byte = frame_len[15:8]; // see RULE_18
        STFG_OFS_LEN_LO: cur_byte = frame_len[7:0]; // see RULE_03
        STFG_OFS_TYPE: cur_byte = frame_type;
        STFG_OFS_FIELD_A: cur_byte = s_q.field_a; // see RULE_05, RULE_12
        STFG_OFS_FIELD_B: cur_byte = s_q.field_b;
        default: cur_byte = ck_check;
      endcase
    end
  end

  // A byte moves into the output register on every free slot while sending.
  assign sending = (s_q.st == ST_SEND) && slot_free;

  // Only bytes from the frame type up to the checksum enter the sum.
  assign ck_add = sending && (s_q.idx >= STFG_OFS_TYPE) && !is_last; // see RULE_04

  // The sum restarts whenever a new frame is loaded.
  assign ck_clear = (s_q.st == ST_IDLE);

  // Next-state logic for the whole generator.
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.suppressed = 1'b0;
    s_d.rejected = 1'b0;

    // A byte accepted by the host leaves the output register.
    if (s_q.out_valid && frame_out_ready) begin
      s_d.out_valid = 1'b0;
    end

    unique case (s_q.st)
      ST_IDLE: begin
        s_d.idx = STFG_OFS_DELIM;
        if (s_q.boot_pending) begin
          // The power-up frame goes out before anything the core reports.
          s_d.boot_pending = 1'b0;
          s_d.is_modem = 1'b1;
          s_d.field_a = STFG_MDM_HW_RESET; // see RULE_17
          s_d.field_b = 8'h00;
          s_d.st = ST_SEND;
        end else if (modem_evt_valid) begin
          // An unknown event code is taken and dropped rather than encoded.
          if (modem_legal) begin
            s_d.is_modem = 1'b1;
            s_d.field_a = modem_code; // see RULE_12
            s_d.field_b = 8'h00;
            s_d.st = ST_SEND;
          end else begin
            s_d.rejected = 1'b1;
          end
        end else if (tx_done_valid) begin
          // A zero tag means the host asked for no answer at all.
          if (tx_done.tag == 8'h00) begin
            s_d.suppressed = 1'b1; // see RULE_02
          end else begin
            s_d.is_modem = 1'b0;
            s_d.field_a = tx_done.tag; // see RULE_05
            s_d.field_b = delivery_code; // see RULE_06, RULE_10
            s_d.st = ST_SEND; // see RULE_01
          end
        end
      end

      ST_SEND: begin
        if (slot_free) begin
          s_d.out_valid = 1'b1;
          s_d.out.data = cur_byte;
          s_d.out.first = (s_q.idx == STFG_OFS_DELIM);
          s_d.out.last = is_last;
          s_d.idx = 3'(s_q.idx + 3'h1);
          if (is_last) begin
            s_d.done = 1'b1;
            s_d.st = ST_IDLE;
          end
        end
      end
    endcase
  end

  // State register; the boot frame is armed by reset itself.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{
        st: ST_IDLE,
        is_modem: 1'b1,
        idx: STFG_OFS_DELIM,
        field_a: 8'h00,
        field_b: 8'h00,
        boot_pending: 1'b1, // see RULE_17
        out_valid: 1'b0,
        out: '0,
        done: 1'b0,
        suppressed: 1'b0,
        rejected: 1'b0
      };
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign frame_out = s_q.out;
  assign frame_out_valid = s_q.out_valid;
  assign frame_busy = (s_q.st == ST_SEND) || s_q.out_valid;
  assign boot_pending = s_q.boot_pending;
  assign frame_done = s_q.done;
  assign tag_suppressed = s_q.suppressed;
  assign event_rejected = s_q.rejected;

endmodule

/* File: shared/stfg_pkg.sv */
// Purpose: Constants and types shared by the status frame generator files.
// Assumes: Frames are built unescaped, one byte per handshake, 100 MHz sys_clk.
// Notes: Offsets count from the start delimiter; the checksum sits after the last field.
package stfg_pkg;

  // Fixed frame bytes.
  localparam logic [7:0] STFG_START_DELIM = 8'h7E;
  localparam logic [7:0] STFG_TYPE_TX_STATUS = 8'h89;
  localparam logic [7:0] STFG_TYPE_MODEM = 8'h8A;
  localparam logic [7:0] STFG_CKSUM_BASE = 8'hFF;

  // Length field values: bytes between the length field and the checksum.
  localparam logic [15:0] STFG_LEN_TX_STATUS = 16'h0003;
  localparam logic [15:0] STFG_LEN_MODEM = 16'h0002;

  // Byte offsets within a frame.
  localparam logic [2:0] STFG_OFS_DELIM = 3'h0;
  localparam logic [2:0] STFG_OFS_LEN_HI = 3'h1;
  localparam logic [2:0] STFG_OFS_LEN_LO = 3'h2;
  localparam logic [2:0] STFG_OFS_TYPE = 3'h3;
  localparam logic [2:0] STFG_OFS_FIELD_A = 3'h4;
  localparam logic [2:0] STFG_OFS_FIELD_B = 3'h5;
  localparam logic [2:0] STFG_OFS_CKSUM_TX = 3'h6;
  localparam logic [2:0] STFG_OFS_CKSUM_MODEM = 3'h5;

  // Delivery status codes.
  localparam logic [7:0] STFG_DLV_SUCCESS = 8'h00;
  localparam logic [7:0] STFG_DLV_MAC_ACK = 8'h01;
  localparam logic [7:0] STFG_DLV_CLEAR_CHANNEL = 8'h02;
  localparam logic [7:0] STFG_DLV_PURGED = 8'h03;
  localparam logic [7:0] STFG_DLV_BAD_CLUSTER = 8'h20;
  localparam logic [7:0] STFG_DLV_NET_ACK = 8'h21;
  localparam logic [7:0] STFG_DLV_NO_ROUTE = 8'h25;
  localparam logic [7:0] STFG_DLV_INTERNAL = 8'h31;
  localparam logic [7:0] STFG_DLV_NO_BUFFERS = 8'h32;
  localparam logic [7:0] STFG_DLV_NO_SESSION = 8'h34;
  localparam logic [7:0] STFG_DLV_ENCRYPT = 8'h35;
  localparam logic [7:0] STFG_DLV_TOO_LARGE = 8'h74;
  localparam logic [7:0] STFG_DLV_UNREQUESTED = 8'h75;

  // Modem status codes.
  localparam logic [7:0] STFG_MDM_HW_RESET = 8'h00;
  localparam logic [7:0] STFG_MDM_WATCHDOG = 8'h01;
  localparam logic [7:0] STFG_MDM_NET_WAKE = 8'h0B;
  localparam logic [7:0] STFG_MDM_NET_SLEEP = 8'h0C;
  localparam logic [7:0] STFG_MDM_SUPPLY = 8'h0D;
  localparam logic [7:0] STFG_MDM_SESS_UP = 8'h3B;
  localparam logic [7:0] STFG_MDM_SESS_END = 8'h3C;
  localparam logic [7:0] STFG_MDM_SESS_AUTH = 8'h3D;
  localparam logic [7:0] STFG_MDM_BLE_DROP = 8'h33;

  // Transmit outcome causes as the radio core reports them.
  typedef enum logic [3:0] {
    TXC_SUCCESS = 4'h0, TXC_MAC_ACK = 4'h1, TXC_CLEAR_CHANNEL = 4'h2, TXC_PURGED = 4'h3,
    TXC_BAD_CLUSTER = 4'h4, TXC_NET_ACK = 4'h5, TXC_NO_ROUTE = 4'h6, TXC_INTERNAL = 4'h7,
    TXC_NO_BUFFERS = 4'h8, TXC_NO_SESSION = 4'h9, TXC_ENCRYPT = 4'hA, TXC_TOO_LARGE = 4'hB,
    TXC_UNREQUESTED = 4'hC
  } stfg_tx_cause_t;

  // Device events that raise a modem status frame.
  typedef enum logic [3:0] {
    MDC_HW_RESET = 4'h0, MDC_WATCHDOG = 4'h1, MDC_NET_WAKE = 4'h2, MDC_NET_SLEEP = 4'h3,
    MDC_SUPPLY = 4'h4, MDC_SESS_UP = 4'h5, MDC_SESS_END = 4'h6, MDC_SESS_AUTH = 4'h7,
    MDC_BLE_DROP = 4'h8
  } stfg_modem_cause_t;

  // Completed transmit request.
  typedef struct packed {
    logic [7:0] tag;
    stfg_tx_cause_t cause;
    logic broadcast;
  } stfg_tx_done_t;

  // One byte of the outgoing frame stream.
  typedef struct packed {
    logic [7:0] data;
    logic first;
    logic last;
  } stfg_byte_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } stfg_state_e_t;

endpackage

/* File: hw/stfg_code_map.sv */
// Purpose: Translates transmit and modem causes into their status code bytes.
// Assumes: Pure combinational logic; callers register the results.
// Notes: Unknown modem cause encodings are flagged; unknown transmit causes encode as internal fault.
`timescale 1ns/100ps
module stfg_code_map
  import stfg_pkg::*;
(
  // Transmit outcome.
  input wire stfg_tx_cause_t tx_cause,
  input wire logic tx_broadcast,
  output logic [7:0] delivery_code,
  // Modem event.
  input wire stfg_modem_cause_t modem_cause,
  output logic [7:0] modem_code,
  output logic modem_legal
);

  // Broadcasts are never acknowledged, so their outcome is always success.
  always_comb begin
    delivery_code = STFG_DLV_INTERNAL;
    if (tx_broadcast) begin
      delivery_code = STFG_DLV_SUCCESS; // see RULE_10
    end else begin
      unique case (tx_cause)
        TXC_SUCCESS: delivery_code = STFG_DLV_SUCCESS; // see RULE_06
        TXC_MAC_ACK: delivery_code = STFG_DLV_MAC_ACK;
        TXC_CLEAR_CHANNEL: delivery_code = STFG_DLV_CLEAR_CHANNEL;
        TXC_PURGED: delivery_code = STFG_DLV_PURGED;
        TXC_BAD_CLUSTER: delivery_code = STFG_DLV_BAD_CLUSTER; // see RULE_07
        TXC_NET_ACK: delivery_code = STFG_DLV_NET_ACK;
        TXC_NO_ROUTE: delivery_code = STFG_DLV_NO_ROUTE;
        TXC_INTERNAL: delivery_code = STFG_DLV_INTERNAL;
        TXC_NO_BUFFERS: delivery_code = STFG_DLV_NO_BUFFERS; // see RULE_08
        TXC_NO_SESSION: delivery_code = STFG_DLV_NO_SESSION;
        TXC_ENCRYPT: delivery_code = STFG_DLV_ENCRYPT;
        TXC_TOO_LARGE: delivery_code = STFG_DLV_TOO_LARGE; // see RULE_09
        TXC_UNREQUESTED: delivery_code = STFG_DLV_UNREQUESTED;
        default: delivery_code = STFG_DLV_INTERNAL; // Unknown cause is an internal fault.
      endcase
    end
  end

  // Modem event codes; encodings past the last event are not legal.
  always_comb begin
    modem_code = STFG_MDM_HW_RESET;
    modem_legal = 1'b1;
    unique case (modem_cause)
      MDC_HW_RESET: modem_code = STFG_MDM_HW_RESET; // see RULE_13
      MDC_WATCHDOG: modem_code = STFG_MDM_WATCHDOG;
      MDC_NET_WAKE: modem_code = STFG_MDM_NET_WAKE; // see RULE_14
      MDC_NET_SLEEP: modem_code = STFG_MDM_NET_SLEEP;
      MDC_SUPPLY: modem_code = STFG_MDM_SUPPLY; // see RULE_15
      MDC_SESS_UP: modem_code = STFG_MDM_SESS_UP; // see RULE_16
      MDC_SESS_END: modem_code = STFG_MDM_SESS_END;
      MDC_SESS_AUTH: modem_code = STFG_MDM_SESS_AUTH;
      MDC_BLE_DROP: modem_code = STFG_MDM_BLE_DROP;
      default: modem_legal = 1'b0;
    endcase
  end

endmodule

/* File: hw/stfg_cksum.sv */
// Purpose: Running byte sum for the frame checksum.
// Assumes: The owner clears it when a frame is loaded and adds each summed byte.
// Notes: The check byte is derived from the stored sum, so it is stable between adds.
`timescale 1ns/100ps
module stfg_cksum
  import stfg_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Control and data.
  input wire logic clear,
  input wire logic add,
  input wire logic [7:0] byte_in,
  output logic [7:0] check
);

  logic [7:0] sum_q;
  logic [7:0] sum_d;

  // Clear wins over add; the two never meet because a load is not a send cycle.
  always_comb begin
    sum_d = sum_q;
    if (clear) begin
      sum_d = 8'h00;
    end else if (add) begin
      sum_d = 8'(sum_q + byte_in);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sum_q <= 8'h00;
    end else begin
      sum_q <= sum_d;
    end
  end

  // Only the low eight bits of the sum take part.
  assign check = 8'(STFG_CKSUM_BASE - sum_q); // see RULE_04

endmodule

/* File: test/stfg_frame_gen_sva.sv */
// Purpose: Port checks on the status frame generator.
// Assumes: One sys_clk domain; resetn is active low.
// Notes: Byte index and sum are rebuilt here from the accepted stream.
`timescale 1ns/100ps
module stfg_frame_gen_sva
  import stfg_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Events.
  input wire logic tx_done_valid,
  input wire stfg_tx_done_t tx_done,
  input wire logic tx_done_ready,
  input wire logic modem_evt_valid,
  input wire stfg_modem_cause_t modem_evt_cause,
  input wire logic modem_evt_ready,
  // Stream and status.
  input wire stfg_byte_t frame_out,
  input wire logic frame_out_valid,
  input wire logic frame_out_ready,
  input wire logic frame_busy,
  input wire logic boot_pending,
  input wire logic frame_done,
  input wire logic tag_suppressed,
  input wire logic event_rejected
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic acc;
  logic tx_take;
  logic [2:0] idx_q;
  logic [7:0] sum_q;
  assign acc = frame_out_valid && frame_out_ready;
  assign tx_take = tx_done_valid && tx_done_ready;
  // Index of the shown byte and the sum from the type byte on.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      idx_q <= 3'h0;
      sum_q <= 8'h00;
    end else if (acc) begin
      idx_q <= frame_out.first ? 3'h1 : idx_q + 3'h1;
      sum_q <= (!frame_out.first && idx_q >= 3'h3) ? sum_q + frame_out.data : 8'h00;
    end
  end
  a_delim_first: assert property (frame_out_valid && frame_out.first |->
    frame_out.data == 8'h7E) else $error("first byte is not the delimiter");
  a_len_hi_zero: assert property (acc && frame_out.first |=>
    frame_out_valid && !frame_out.first && frame_out.data == 8'h00)
    else $error("length high byte wrong");
  a_cksum_last: assert property (frame_out_valid && frame_out.last |->
    frame_out.data == 8'hFF - sum_q && idx_q inside {3'h5, 3'h6})
    else $error("checksum byte wrong");
  a_stall_hold: assert property (frame_out_valid && !frame_out_ready |=>
    frame_out_valid && $stable(frame_out)) else $error("byte changed while stalled");
  a_boot_frame: assert property ($fell(boot_pending) |=>
    frame_out_valid && frame_out.first) else $error("power-up frame late");
  a_boot_once: assert property (boot_pending |=> !boot_pending)
    else $error("boot pending stuck");
  // The last byte of the previous frame may still wait in the register, so look for a start.
  a_zero_tag: assert property (tx_take && tx_done.tag == 8'h00 |=>
    tag_suppressed ##1 !(frame_out_valid && frame_out.first))
    else $error("zero tag not dropped");
  a_tx_answer: assert property (tx_take && tx_done.tag != 8'h00 &&
    (!frame_out_valid || frame_out_ready) |-> ##2 frame_out_valid && frame_out.first)
    else $error("no frame for result");
  // Between frames only the closing byte of the last frame may still be unsent.
  a_modem_wins: assert property (tx_done_ready |-> !modem_evt_valid && !boot_pending &&
    (!frame_busy || (frame_out_valid && frame_out.last)))
    else $error("result taken too early");
  a_bad_cause: assert property (modem_evt_valid && modem_evt_ready &&
    modem_evt_cause > MDC_BLE_DROP |=> event_rejected) else $error("bad cause kept");
  // The pulse comes in the cycle the closing byte first shows, whatever the host does.
  a_done_pulse: assert property (frame_out_valid && frame_out.last &&
    !$past(frame_out_valid && frame_out.last) |-> frame_done ##1 !frame_done)
    else $error("done pulse wrong");
  c_boot: cover property ($fell(boot_pending));
  c_stall: cover property (frame_out_valid && !frame_out_ready);
  c_zero: cover property (tag_suppressed);
  c_reject: cover property (event_rejected);
endmodule
bind stfg_frame_gen stfg_frame_gen_sva stfg_frame_gen_sva_inst (.sys_clk, .resetn,
  .tx_done_valid, .tx_done, .tx_done_ready, .modem_evt_valid, .modem_evt_cause,
  .modem_evt_ready, .frame_out, .frame_out_valid, .frame_out_ready, .frame_busy,
  .boot_pending, .frame_done, .tag_suppressed, .event_rejected);

/* File: test/stfg_host_model.sv */
// Purpose: Host side that takes frame bytes and keeps the last frame.
// Assumes: Ready changes only just after a rising edge.
// Notes: In slow mode ready is high every other cycle.
`timescale 1ns/100ps
module stfg_host_model
  import stfg_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Byte stream.
  input wire stfg_byte_t frame_out,
  input wire logic frame_out_valid,
  output logic frame_out_ready,
  // Control and capture.
  input wire logic slow,
  output logic [55:0] rx_bytes,
  output logic [7:0] rx_frames,
  output logic rx_cks_ok
);
  logic [2:0] len_q;
  logic [7:0] sum_q;
  logic tick_q;
  // Frames are taken as they come; no legacy switch is modelled.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      frame_out_ready <= 1'b0;
      tick_q <= 1'b0;
      rx_bytes <= '0;
      rx_frames <= 8'h00;
      rx_cks_ok <= 1'b0;
      len_q <= 3'h0;
      sum_q <= 8'h00;
    end else begin
      tick_q <= !tick_q;
      frame_out_ready <= !slow || tick_q;
      if (frame_out_valid && frame_out_ready) begin
        rx_bytes <= frame_out.first ? {48'h0, frame_out.data} : {rx_bytes[47:0], frame_out.data};
        len_q <= frame_out.first ? 3'h1 : len_q + 3'h1;
        // Sum runs from the type byte; the last byte is judged against it.
        sum_q <= (!frame_out.first && len_q >= 3'h3) ? sum_q + frame_out.data : 8'h00;
        if (frame_out.last) begin
          rx_frames <= rx_frames + 8'h01;
          rx_cks_ok <= frame_out.data == 8'hFF - sum_q;
        end
      end
    end
  end
endmodule

/* File: test/status_frame_generator_tb_top.sv */
// Purpose: Self-checking bench for the status frame generator.
// Assumes: Inputs change at the falling edge of sys_clk.
// Notes: Whole frames are compared as captured by the host model.
`timescale 1ns/100ps
module status_frame_generator_tb_top;
  import stfg_pkg::*;
  logic sys_clk, resetn, slow, tx_done_valid, tx_done_ready, modem_evt_valid;
  logic modem_evt_ready, frame_out_valid, frame_out_ready, tag_suppressed, event_rejected;
  logic rx_cks_ok;
  stfg_tx_done_t tx_done;
  stfg_modem_cause_t modem_evt_cause;
  stfg_byte_t frame_out;
  logic [55:0] rx_bytes;
  logic [7:0] rx_frames;
  int errors, samples_checked;
  localparam logic [7:0] DLV [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h20, 8'h21, 8'h25,
    8'h31, 8'h32, 8'h34, 8'h35, 8'h74, 8'h75};
  localparam logic [7:0] MDM [9] = '{8'h00, 8'h01, 8'h0B, 8'h0C, 8'h0D, 8'h3B, 8'h3C,
    8'h3D, 8'h33};
  stfg_frame_gen stfg_frame_gen_inst (.sys_clk, .resetn, .tx_done_valid, .tx_done,
    .tx_done_ready, .modem_evt_valid, .modem_evt_cause, .modem_evt_ready, .frame_out,
    .frame_out_valid, .frame_out_ready, .frame_busy(), .boot_pending(), .frame_done(),
    .tag_suppressed, .event_rejected);
  stfg_host_model stfg_host_model_inst (.sys_clk, .resetn, .frame_out, .frame_out_valid,
    .frame_out_ready, .slow, .rx_bytes, .rx_frames, .rx_cks_ok);
  // Free-running clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = !sys_clk;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [55:0] seen, input logic [55:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Expected frame, packed as the host model stores it.
  function automatic logic [55:0] mk(input logic is_tx, input logic [7:0] a, input logic [7:0] b);
    logic [7:0] c;
    c = 8'hFF - ((is_tx ? 8'h89 : 8'h8A) + a + (is_tx ? b : 8'h00));
    return is_tx ? {8'h7E, 8'h00, 8'h03, 8'h89, a, b, c} : {8'h00, 8'h7E, 8'h00, 8'h02, 8'h8A, a, c};
  endfunction
  // Waits, bounded, for the frame count to move past n0 and compares the frame.
  task automatic see_frame(input logic [7:0] n0, input logic [55:0] exp);
    int i;
    for (i = 0; i < 300 && rx_frames === n0; i++) @(negedge sys_clk);
    if (rx_frames === n0) begin
      errors++;
      give_verdict();
    end
    check("frame", rx_bytes, exp);
    check("cks", rx_cks_ok, 56'h1);
  endtask
  // Offers one event, holds it until taken, then reports the pulses.
  task automatic offer(input logic is_tx, input stfg_tx_done_t t, input stfg_modem_cause_t m,
    output logic supp, output logic rej);
    int i;
    if (is_tx) begin
      tx_done = t;
      tx_done_valid = 1'b1;
    end else begin
      modem_evt_cause = m;
      modem_evt_valid = 1'b1;
    end
    for (i = 0; i < 300; i++) begin
      #1;
      if ((is_tx ? tx_done_ready : modem_evt_ready) === 1'b1) break;
      @(negedge sys_clk);
    end
    if (i == 300) begin
      errors++;
      give_verdict();
    end
    @(negedge sys_clk);
    if (is_tx) tx_done_valid = 1'b0;
    else modem_evt_valid = 1'b0;
    supp = tag_suppressed;
    rej = event_rejected;
  endtask
  task automatic t_boot();
    see_frame(8'h00, mk(1'b0, 8'h00, 8'h00));
  endtask
  task automatic t_tx_codes();
    logic s, r;
    for (int k = 0; k < 13; k++) begin
      slow = k[0];
      offer(1'b1, '{8'h52 + k[7:0], stfg_tx_cause_t'(k), 1'b0}, MDC_HW_RESET, s, r);
      see_frame(rx_frames, mk(1'b1, 8'h52 + k[7:0], DLV[k]));
    end
    offer(1'b1, '{8'hC3, TXC_NO_ROUTE, 1'b1}, MDC_HW_RESET, s, r);
    see_frame(rx_frames, mk(1'b1, 8'hC3, 8'h00));
    offer(1'b1, '{8'hD4, stfg_tx_cause_t'(4'hE), 1'b0}, MDC_HW_RESET, s, r);
    see_frame(rx_frames, mk(1'b1, 8'hD4, 8'h31));
    slow = 1'b0;
  endtask
  task automatic t_drops();
    logic s, r;
    logic [7:0] n0;
    n0 = rx_frames;
    offer(1'b1, '{8'h00, TXC_MAC_ACK, 1'b0}, MDC_HW_RESET, s, r);
    check("suppressed", s, 56'h1);
    offer(1'b0, '0, stfg_modem_cause_t'(4'hA), s, r);
    check("rejected", r, 56'h1);
    repeat (20) @(negedge sys_clk);
    check("no frame", rx_frames, n0);
  endtask
  task automatic t_modem_codes();
    logic s, r;
    for (int k = 0; k < 9; k++) begin
      offer(1'b0, '0, stfg_modem_cause_t'(k), s, r);
      see_frame(rx_frames, mk(1'b0, MDM[k], 8'h00));
    end
  endtask
  // Both events at once: the modem frame goes first.
  task automatic t_priority();
    logic s, r;
    logic [7:0] n0;
    n0 = rx_frames;
    tx_done = '{8'h7A, TXC_ENCRYPT, 1'b0};
    tx_done_valid = 1'b1;
    offer(1'b0, '0, MDC_SUPPLY, s, r);
    offer(1'b1, tx_done, MDC_HW_RESET, s, r);
    check("first", rx_bytes, mk(1'b0, 8'h0D, 8'h00));
    see_frame(n0 + 8'h01, mk(1'b1, 8'h7A, 8'h35));
  endtask
  // Reset in mid-frame brings a fresh power-up frame.
  task automatic t_reset_mid();
    logic s, r;
    offer(1'b1, '{8'h11, TXC_TOO_LARGE, 1'b0}, MDC_HW_RESET, s, r);
    @(negedge sys_clk);
    resetn = 1'b0;
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    t_boot();
  endtask
  initial begin
    errors = 0;
    samples_checked = 0;
    resetn = 1'b0;
    slow = 1'b0;
    tx_done_valid = 1'b0;
    tx_done = '0;
    modem_evt_valid = 1'b0;
    modem_evt_cause = MDC_HW_RESET;
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    t_boot();
    t_tx_codes();
    t_drops();
    t_modem_codes();
    t_priority();
    t_reset_mid();
    give_verdict();
  end
endmodule
